/* File: rtl/fram_spi_pkg.sv */
// Constants, opcodes and state encodings for the serial memory front end
package fram_spi_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DEPTH  = 8192;
  localparam int unsigned BYTE_W = 8;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] WRITE_LATCH_SET_CMD   = 8'h06;
  localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] MEM_READ_CMD          = 8'h03;
  localparam logic [7:0] MEM_WRITE_CMD         = 8'h02;

  // ==========================================================
  // Status byte field positions and reset values
  localparam int unsigned STAT_PROT_EN_BIT = 7;
  localparam int unsigned STAT_BLK1_BIT    = 3;
  localparam int unsigned STAT_BLK0_BIT    = 2;
  localparam int unsigned STAT_LATCH_BIT   = 1;
  localparam logic        PROT_EN_RST      = 1'b0;
  localparam logic        BLK_RST          = 1'b0;
  localparam logic        LATCH_RST        = 1'b0;

  // ==========================================================
  // Bit counter values
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // ==========================================================
  // Decoded command and link state
  typedef enum logic [2:0] {
    CMD_SET    = 3'b000,
    CMD_CLEAR  = 3'b001,
    CMD_SREAD  = 3'b010,
    CMD_SWRITE = 3'b011,
    CMD_MREAD  = 3'b100,
    CMD_MWRITE = 3'b101,
    CMD_BAD    = 3'b110
  } cmd_e;

  typedef enum logic [3:0] {
    ST_OPCODE  = 4'b0000,
    ST_ADDR_HI = 4'b0001,
    ST_ADDR_LO = 4'b0010,
    ST_READ    = 4'b0011,
    ST_WRITE   = 4'b0100,
    ST_STAT_O  = 4'b0101,
    ST_STAT_I  = 4'b0110,
    ST_DONE    = 4'b0111,
    ST_IGNORE  = 4'b1000
  } link_state_e;

endpackage : fram_spi_pkg

/* File: rtl/serial_fram_spi_slave_front_end.sv */
// Serial memory slave front end: link engine on sck, report side on clk
// Function
// - Thirteen-bit address picks one of 8192 bytes.
// - Top three address bits of the two address bytes are dropped.
// - Writes finish at bus speed; never busy.
// - Serial input sampled on rising edges from first edge after select.
// - Serial output changes on falling edges.
// - Clock level at select fall chooses mode 0 or mode 3.
// - In mode 3 the idle high level is not an edge.
// - First byte after select is the opcode, then address and data.
// - One opcode per selection; new command needs fresh select fall.
// - Deselected: input ignored, output high impedance.
// - All bytes move most significant bit first.
// - Bad opcode: ignore everything until next select, output off.
// - Latch set 06h, latch clear 04h, status read 05h.
// - Status write 01h, memory read 03h, memory write 02h only.
// - Eight-bit status register configures the device; its protect bits are only stored and read back, and block no write.
// - Slave only; answers the master, never starts traffic.
// - Address increments per data byte, wrapping top to zero.
// - Latch set opcode sets the write latch; clear at power-up.
// - Latch clear owed after clear, status write, memory write; applied on first edge of next frame.
// - Status read shifts out one status byte.
`timescale 1ns/10ps
module serial_fram_spi_slave_front_end (
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            csn,
  input  wire logic                            sck,
  input  wire logic                            si,
  output logic                                 so_out,
  output logic                                 so_oe,
  output logic                                 write_event,
  output logic [fram_spi_pkg::ADDR_W-1:0]      write_addr,
  output logic [fram_spi_pkg::BYTE_W-1:0]      write_data,
  output logic                                 spi_mode3,
  output logic                                 write_latch_flag
);

  // ==========================================================
  // Declarations
  logic                              rst_meta;
  logic                              rst_n;
  logic                              frame_rst;
  fram_spi_pkg::link_state_e         state;
  logic [2:0]                        bit_cnt;
  logic [7:0]                        shift;
  logic [7:0]                        rx_byte;
  logic                              byte_done;
  logic [7:0]                        tx_byte;
  logic [fram_spi_pkg::ADDR_W-1:0]   addr;
  logic [fram_spi_pkg::ADDR_W-1:0]   next_addr;
  logic [4:0]                        addr_hi;
  logic                              is_read;
  fram_spi_pkg::cmd_e                cmd;
  logic                              latch;
  logic                              clear_due;
  logic                              prot_en;
  logic                              blk1;
  logic                              blk0;
  logic [7:0]                        status_byte;
  logic                              wr_toggle;
  logic [fram_spi_pkg::ADDR_W-1:0]   held_addr;
  logic [7:0]                        held_data;
  logic                              tog_s1;
  logic                              tog_s2;
  logic                              tog_s3;
  logic                              csn_s1;
  logic                              csn_s2;
  logic                              csn_s3;
  logic                              sck_s1;
  logic                              sck_s2;
  logic                              sel_sck;
  logic                              latch_s1;

  store_if sif ();

  // ==========================================================
  // Opcode decode
  function automatic fram_spi_pkg::cmd_e decode_op(input logic [7:0] op);
    fram_spi_pkg::cmd_e c;
    c = fram_spi_pkg::CMD_BAD;
    case (op)
      fram_spi_pkg::WRITE_LATCH_SET_CMD:   c = fram_spi_pkg::CMD_SET;
      fram_spi_pkg::WRITE_LATCH_CLEAR_CMD: c = fram_spi_pkg::CMD_CLEAR;
      fram_spi_pkg::STATUS_READ_CMD:       c = fram_spi_pkg::CMD_SREAD;
      fram_spi_pkg::STATUS_WRITE_CMD:      c = fram_spi_pkg::CMD_SWRITE;
      fram_spi_pkg::MEM_READ_CMD:          c = fram_spi_pkg::CMD_MREAD;
      fram_spi_pkg::MEM_WRITE_CMD:         c = fram_spi_pkg::CMD_MWRITE;
      default:                             c = fram_spi_pkg::CMD_BAD;
    endcase
    return c;
  endfunction : decode_op

  // ==========================================================
  // Reset release through two flops on clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Frame state dies with the select line; sck may stop when deselected
  assign frame_rst = csn | ~rst_n;

  // ==========================================================
  // Link side: receive path
  assign rx_byte   = {shift[6:0], si};
  assign byte_done = (bit_cnt == fram_spi_pkg::BIT_LAST);
  assign cmd       = decode_op(rx_byte);

  // Bit counter; rising edges only, so a mode 3 idle high is not counted
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= fram_spi_pkg::BIT_FIRST;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Input shifter, oldest bit ends in the top position
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      shift <= 8'h00;
    end else begin
      shift <= rx_byte;
    end
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      state   <= fram_spi_pkg::ST_OPCODE;
      is_read <= 1'b0;
    end else begin
      case (state)
        fram_spi_pkg::ST_OPCODE: begin
          if (byte_done) begin
            case (cmd)
              fram_spi_pkg::CMD_SREAD:  state <= fram_spi_pkg::ST_STAT_O;
              fram_spi_pkg::CMD_SWRITE: state <= fram_spi_pkg::ST_STAT_I;
              fram_spi_pkg::CMD_MREAD: begin
                state   <= fram_spi_pkg::ST_ADDR_HI;
                is_read <= 1'b1;
              end
              fram_spi_pkg::CMD_MWRITE: state <= fram_spi_pkg::ST_ADDR_HI;
              fram_spi_pkg::CMD_BAD:    state <= fram_spi_pkg::ST_IGNORE;
              default:                  state <= fram_spi_pkg::ST_DONE;
            endcase
          end
        end
        fram_spi_pkg::ST_ADDR_HI: begin
          if (byte_done) begin
            state <= fram_spi_pkg::ST_ADDR_LO;
          end
        end
        fram_spi_pkg::ST_ADDR_LO: begin
          if (byte_done) begin
            state <= is_read ? fram_spi_pkg::ST_READ : fram_spi_pkg::ST_WRITE;
          end
        end
        fram_spi_pkg::ST_STAT_O: begin
          if (byte_done) begin
            state <= fram_spi_pkg::ST_DONE;
          end
        end
        fram_spi_pkg::ST_STAT_I: begin
          if (byte_done) begin
            state <= fram_spi_pkg::ST_DONE;
          end
        end
        // Bursts run until deselect; done and ignore hold until then
        fram_spi_pkg::ST_READ,
        fram_spi_pkg::ST_WRITE,
        fram_spi_pkg::ST_DONE,
        fram_spi_pkg::ST_IGNORE: state <= state;
        default: state <= fram_spi_pkg::ST_IGNORE;
      endcase
    end
  end

  // ==========================================================
  // Address capture and increment
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      addr_hi <= 5'h00;
      addr    <= '0;
    end else if (byte_done) begin
      case (state)
        fram_spi_pkg::ST_ADDR_HI: addr_hi <= rx_byte[4:0];
        fram_spi_pkg::ST_ADDR_LO: addr    <= is_read ? next_addr : {addr_hi, rx_byte};
        fram_spi_pkg::ST_READ:    addr    <= next_addr;
        fram_spi_pkg::ST_WRITE:   addr    <= next_addr;
        default:                  addr    <= addr;
      endcase
    end
  end

  // Read address; the first read byte is fetched as the low address lands
  always_comb begin
    if (state == fram_spi_pkg::ST_ADDR_LO) begin
      sif.rd_addr = {addr_hi, rx_byte};
    end else begin
      sif.rd_addr = addr;
    end
  end

  // Natural 13-bit overflow gives the wrap from the top byte to zero
  assign next_addr = sif.rd_addr + 13'h0001;

  // ==========================================================
  // Memory write port; no busy state, the byte lands on its last edge
  assign sif.wr_en   = (state == fram_spi_pkg::ST_WRITE) && byte_done && latch;
  assign sif.wr_addr = addr;
  assign sif.wr_data = rx_byte;

  spi_byte_store u_store (
    .sck  (sck),
    .port (sif.store)
  );

  // ==========================================================
  // Write latch; power-on value is clear
  // The clear owed from a deselect is applied on the first edge of the
  // next frame, since sck may not run between frames
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      latch     <= fram_spi_pkg::LATCH_RST;
      clear_due <= 1'b0;
    end else if (!csn) begin
      if ((state == fram_spi_pkg::ST_OPCODE) && byte_done) begin
        if (cmd == fram_spi_pkg::CMD_SET) begin
          latch <= 1'b1;
        end else if ((cmd == fram_spi_pkg::CMD_CLEAR) || (cmd == fram_spi_pkg::CMD_SWRITE) ||
                     (cmd == fram_spi_pkg::CMD_MWRITE)) begin
          clear_due <= 1'b1;
        end
      end else if ((state == fram_spi_pkg::ST_OPCODE) && (bit_cnt == fram_spi_pkg::BIT_FIRST)
                   && clear_due) begin
        latch     <= 1'b0;
        clear_due <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status register; only the protect bits are writable
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      prot_en <= fram_spi_pkg::PROT_EN_RST;
      blk1    <= fram_spi_pkg::BLK_RST;
      blk0    <= fram_spi_pkg::BLK_RST;
    end else if (!csn && (state == fram_spi_pkg::ST_STAT_I) && byte_done && latch) begin
      prot_en <= rx_byte[fram_spi_pkg::STAT_PROT_EN_BIT];
      blk1    <= rx_byte[fram_spi_pkg::STAT_BLK1_BIT];
      blk0    <= rx_byte[fram_spi_pkg::STAT_BLK0_BIT];
    end
  end

  // Unused positions read as zero; latch shows its pending value
  always_comb begin
    status_byte = 8'h00;
    status_byte[fram_spi_pkg::STAT_PROT_EN_BIT] = prot_en;
    status_byte[fram_spi_pkg::STAT_BLK1_BIT]    = blk1;
    status_byte[fram_spi_pkg::STAT_BLK0_BIT]    = blk0;
    status_byte[fram_spi_pkg::STAT_LATCH_BIT]   = latch;
  end

  // ==========================================================
  // Transmit byte, loaded at the end of the byte before it is shifted out
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_byte <= 8'h00;
    end else if (byte_done) begin
      if ((state == fram_spi_pkg::ST_OPCODE) && (cmd == fram_spi_pkg::CMD_SREAD)) begin
        tx_byte <= status_byte;
      end else if ((state == fram_spi_pkg::ST_ADDR_LO && is_read) ||
                   (state == fram_spi_pkg::ST_READ)) begin
        tx_byte <= sif.rd_data;
      end
    end
  end

  // Output bit moves on the falling edge, top bit first
  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_out <= 1'b0;
    end else begin
      so_out <= tx_byte[3'h7 - bit_cnt];
    end
  end

  // Drive only while selected and answering; never on our own
  assign so_oe = !csn && ((state == fram_spi_pkg::ST_READ) ||
                          (state == fram_spi_pkg::ST_STAT_O));

  // ==========================================================
  // Write report, link side: toggle plus held word
  // Held word is stable at least eight sck periods, far longer than the
  // three clk edges the far side needs to see the toggle
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      wr_toggle <= 1'b0;
      held_addr <= '0;
      held_data <= 8'h00;
    end else if (!csn && sif.wr_en) begin
      wr_toggle <= ~wr_toggle;
      held_addr <= addr;
      held_data <= rx_byte;
    end
  end

  // ==========================================================
  // Report side on clk: toggle synchroniser and edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= wr_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // Capture the held word when the toggle is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_event <= 1'b0;
      write_addr  <= '0;
      write_data  <= 8'h00;
    end else begin
      write_event <= tog_s2 ^ tog_s3;
      if (tog_s2 ^ tog_s3) begin
        write_addr <= held_addr;
        write_data <= held_data;
      end
    end
  end

  // ==========================================================
  // Clock level caught at the select fall itself; a later clk sample may see the first edge
  always_ff @(negedge csn or negedge rst_n) begin
    if (!rst_n) begin
      sel_sck <= 1'b0;
    end else begin
      sel_sck <= sck;
    end
  end

  // Mode detect: clock level seen when select falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
      csn_s3 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
    end else begin
      csn_s1 <= csn;
      csn_s2 <= csn_s1;
      csn_s3 <= csn_s2;
      sck_s1 <= sel_sck;
      sck_s2 <= sck_s1;
    end
  end

  // Report only; the engine needs no mode since it samples on rising edges and drives on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_mode3 <= 1'b0;
    end else if (csn_s3 && !csn_s2) begin
      spi_mode3 <= sck_s2;
    end
  end

  // ==========================================================
  // Latch level brought across for the user side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_s1         <= 1'b0;
      write_latch_flag <= 1'b0;
    end else begin
      latch_s1         <= latch;
      write_latch_flag <= latch_s1;
    end
  end

endmodule : serial_fram_spi_slave_front_end

/* File: rtl/spi_byte_store.sv */
// Byte array written on the serial clock and read combinationally
`timescale 1ns/10ps
module spi_byte_store (
  input  wire logic sck,
  store_if.store    port
);

  logic [fram_spi_pkg::BYTE_W-1:0] mem [fram_spi_pkg::DEPTH];

  // ==========================================================
  // Write lands on the same edge the last data bit arrives
  always_ff @(posedge sck) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  // Read is combinational so the next byte is ready at once
  assign port.rd_data = mem[port.rd_addr];

endmodule : spi_byte_store

/* File: rtl/store_if.sv */
// Carrier between the link engine and the byte store
`timescale 1ns/10ps
interface store_if;
  logic                            wr_en;
  logic [fram_spi_pkg::ADDR_W-1:0] wr_addr;
  logic [fram_spi_pkg::BYTE_W-1:0] wr_data;
  logic [fram_spi_pkg::ADDR_W-1:0] rd_addr;
  logic [fram_spi_pkg::BYTE_W-1:0] rd_data;

  modport engine (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : store_if

/* File: test/fram_spi_props.sv */
// Concurrent checks on the serial memory front end ports
`timescale 1ns/10ps
module fram_spi_props (
  input wire logic                            clk,
  input wire logic                            resetn,
  input wire logic                            csn,
  input wire logic                            sck,
  input wire logic                            si,
  input wire logic                            so_out,
  input wire logic                            so_oe,
  input wire logic                            write_event,
  input wire logic [fram_spi_pkg::ADDR_W-1:0] write_addr,
  input wire logic [fram_spi_pkg::BYTE_W-1:0] write_data,
  input wire logic                            spi_mode3,
  input wire logic                            write_latch_flag
);
  // ==========================================================
  // Link domain helpers
  logic [7:0] rises;
  logic       so_at_rise;

  // Rising edges since select fell; saturates so long read bursts stay legal
  always_ff @(posedge sck or posedge csn) begin
    if (csn) rises <= 8'h00;
    else if (rises != 8'hff) rises <= rises + 8'h01;
  end

  // Output level seen at each rising edge, compared at the next falling edge
  always_ff @(posedge sck) begin
    so_at_rise <= so_out;
  end

  // ==========================================================
  // Link domain assertions
  so_fall_a: assert property (@(negedge sck) disable iff (csn || !resetn)
    so_oe |-> so_out == so_at_rise) else $error("serial output moved between rising and falling edge");
  oe_after_op_a: assert property (@(negedge sck) disable iff (csn || !resetn)
    so_oe |-> rises >= 8'h08) else $error("serial output driven before the opcode was complete");

  // ==========================================================
  // System clock assertions
  oe_desel_a: assert property (@(posedge clk) disable iff (!resetn)
    csn |-> !so_oe && !so_out) else $error("serial output active while deselected");
  event_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    write_event |=> !write_event [*4]) else $error("write report pulse too long or too dense");
  addr_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(write_addr) |-> write_event) else $error("write address moved without a write report");
  data_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(write_data) |-> write_event) else $error("write data moved without a write report");
  latch_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    write_event |-> write_latch_flag) else $error("memory written while the write latch was clear");
  reset_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> (!write_event && !write_latch_flag) [*2]) else $error("outputs not quiet after reset");

  // Main scenarios reached
  cover property (@(posedge clk) write_event);
  cover property (@(posedge clk) so_oe);
  cover property (@(posedge clk) spi_mode3);
  cover property (@(posedge clk) $fell(write_latch_flag));
endmodule : fram_spi_props

bind serial_fram_spi_slave_front_end fram_spi_props fram_spi_props_i (.clk(clk), .resetn(resetn), .csn(csn),
  .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe), .write_event(write_event), .write_addr(write_addr),
  .write_data(write_data), .spi_mode3(spi_mode3), .write_latch_flag(write_latch_flag));

/* File: test/serial_fram_spi_slave_front_end_bench.sv */
// Self-checking bench for the serial memory front end against a reference model
`timescale 1ns/10ps
module serial_fram_spi_slave_front_end_bench;
  // ==========================================================
  // Signals and model state
  logic                            clk = 1'b0;
  logic                            resetn = 1'b0;
  logic                            csn;
  logic                            sck;
  logic                            si;
  logic                            so_out;
  logic                            so_oe;
  logic                            write_event;
  logic [fram_spi_pkg::ADDR_W-1:0] write_addr;
  logic [fram_spi_pkg::BYTE_W-1:0] write_data;
  logic                            spi_mode3;
  logic                            write_latch_flag;
  wire                             so_line;
  int                              bad_count = 0;
  int                              check_count = 0;
  int                              cycles = 0;
  int                              oe_cnt, latch, owed, k, m, seed;
  logic [7:0]                      stat;
  logic [7:0]                      mem [int];
  logic [20:0]                     exp_wr [$];
  logic [20:0]                     got_wr [$];
  logic [63:0]                     tx, rx;
  logic [55:0]                     b;

  always #10 clk = ~clk;
  // Bench resolves the tristate output pin
  assign so_line = so_oe ? so_out : 1'bz;

  serial_fram_spi_slave_front_end serial_fram_spi_slave_front_end_i (.clk(clk), .resetn(resetn), .csn(csn),
    .sck(sck), .si(si), .so_out(so_out), .so_oe(so_oe), .write_event(write_event), .write_addr(write_addr),
    .write_data(write_data), .spi_mode3(spi_mode3), .write_latch_flag(write_latch_flag));
  spi_master_model spi_master_model_i (.csn(csn), .sck(sck), .si(si), .so(so_line));

  // ==========================================================
  // Comparison and closing
  task tally(input bit ok, input string what);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : tally
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, $sformatf("byte got %h exp %h", got, exp));
  endtask : chk_byte
  task chk_wr(input logic [20:0] got, input logic [20:0] exp);
    tally(got === exp, $sformatf("write report got %h exp %h", got, exp));
  endtask : chk_wr
  task chk_flag(input logic got, input logic exp);
    tally(got === exp, $sformatf("flag got %b exp %b", got, exp));
  endtask : chk_flag
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Report capture, output activity and hang guard
  always @(posedge clk) begin
    cycles++;
    if (write_event === 1'b1) got_wr.push_back({write_addr, write_data});
    if (so_oe === 1'b1) oe_cnt++;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end

  function automatic logic [55:0] rb();
    return {$urandom(), 24'($urandom())};
  endfunction : rb

  // ==========================================================
  // One frame through the master, then the reference model's view of it
  task send(input logic [7:0] op, input logic [55:0] body, input bit m3, input int n, input int slow);
    logic [12:0] a;
    tx = {op, body};
    a = tx[52:40];
    @(posedge clk);
    #1;
    oe_cnt = 0;
    if (owed != 0) latch = 0;
    owed = 0;
    spi_master_model_i.frame(m3, n, slow, tx, rx);
    repeat (6) @(posedge clk); // Report path and flag syncs settle in fewer cycles
    case (op)
      fram_spi_pkg::WRITE_LATCH_SET_CMD: latch = 1;
      fram_spi_pkg::WRITE_LATCH_CLEAR_CMD: owed = 1;
      fram_spi_pkg::STATUS_READ_CMD: chk_byte(rx[7:0], {stat[7], 3'b000, stat[3:2], latch[0], 1'b0});
      fram_spi_pkg::STATUS_WRITE_CMD: begin
        if (latch != 0) stat = tx[55:48] & 8'h8c;
        owed = 1;
      end
      fram_spi_pkg::MEM_WRITE_CMD: begin
        for (k = 3; k < n; k++) begin
          if (latch != 0) exp_wr.push_back({a, tx[63 - 8 * k -: 8]});
          if (latch != 0) mem[a] = tx[63 - 8 * k -: 8];
          a++;
        end
        owed = 1;
      end
      fram_spi_pkg::MEM_READ_CMD: begin
        for (k = 3; k < n; k++) begin
          chk_byte(rx[8 * (n - 1 - k) +: 8], mem[a]);
          a++;
        end
      end
      default: ;
    endcase
    chk_flag(oe_cnt != 0, op == fram_spi_pkg::STATUS_READ_CMD || op == fram_spi_pkg::MEM_READ_CMD);
    chk_flag(spi_mode3, m3);
    chk_flag(write_latch_flag, latch[0]);
    while (exp_wr.size() > 0 || got_wr.size() > 0) begin
      chk_wr(got_wr.size() > 0 ? got_wr.pop_front() : 'x, exp_wr.size() > 0 ? exp_wr.pop_front() : 'x);
    end
  endtask : send

  // ==========================================================
  // Main sequence
  initial begin
    seed = $urandom(29);
    latch = 0;
    owed = 0;
    stat = 8'h00;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (10) @(posedge clk);
    send(fram_spi_pkg::STATUS_READ_CMD, 56'h0, 1'b0, 2, 0);
    send(fram_spi_pkg::MEM_WRITE_CMD, rb(), 1'b0, 5, 0);
    send(fram_spi_pkg::WRITE_LATCH_SET_CMD, rb(), 1'b1, 3, 0);
    send(fram_spi_pkg::STATUS_READ_CMD, 56'h0, 1'b1, 2, 0);
    for (m = 0; m < 2; m++) begin
      send(fram_spi_pkg::WRITE_LATCH_SET_CMD, 56'h0, m[0], 1, 0);
      b = rb();
      b[52:40] = 13'h1ffe;
      b[55:53] = 3'h0;
      send(fram_spi_pkg::MEM_WRITE_CMD, b, m[0], 7, m * 20);
      b[55:53] = 3'($urandom());
      send(fram_spi_pkg::MEM_READ_CMD, b, !m[0], 7, 0);
      send(fram_spi_pkg::STATUS_READ_CMD, 56'h0, m[0], 2, 0);
    end
    send(fram_spi_pkg::WRITE_LATCH_SET_CMD, 56'h0, 1'b0, 1, 0);
    send(fram_spi_pkg::STATUS_WRITE_CMD, rb(), 1'b0, 2, 0);
    send(fram_spi_pkg::STATUS_WRITE_CMD, rb(), 1'b0, 2, 0);
    send(fram_spi_pkg::STATUS_READ_CMD, 56'h0, 1'b0, 2, 0);
    send(fram_spi_pkg::WRITE_LATCH_SET_CMD, 56'h0, 1'b1, 1, 0);
    send(fram_spi_pkg::WRITE_LATCH_CLEAR_CMD, rb(), 1'b1, 2, 0);
    send(fram_spi_pkg::MEM_WRITE_CMD, rb(), 1'b1, 5, 0);
    // Unlisted opcodes with the latch set must still write nothing
    send(fram_spi_pkg::WRITE_LATCH_SET_CMD, 56'h0, 1'b0, 1, 0);
    for (m = 0; m < 4; m++) begin
      send(8'($urandom()) | 8'h08, rb(), m[0], 5, 0);
    end
    send(fram_spi_pkg::STATUS_READ_CMD, 56'h0, 1'b0, 2, 0);
    results();
  end
endmodule : serial_fram_spi_slave_front_end_bench

/* File: test/spi_master_model.sv */
// Serial bus master that frames commands for the memory front end
`timescale 1ns/10ps
module spi_master_model (
  output logic      csn,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  // Idle: deselected, clock low, data parked
  initial begin
    csn = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  // One frame of n bytes, first byte in tx[63:56]; slow stretches the low phase
  task frame(input bit m3, input int n, input int slow, input logic [63:0] tx, output logic [63:0] rx);
    int i;
    rx = 64'h0000_0000_0000_0000;
    sck = m3;
    #20 csn = 1'b0;
    for (i = 0; i < 8 * n; i++) begin
      #7.5 sck = 1'b0;
      si = tx[63 - i];
      #(7.5 + slow) sck = 1'b1;
      rx = {rx[62:0], so};
    end
    #7.5 sck = m3;
    #7.5 csn = 1'b1;
    si = ~si; // Released line must not keep the last bit
  endtask : frame
endmodule : spi_master_model
